/* verilog/pulse_gen_cfg.svh */
// constants for the paired pulse generator: mode codes, clock codes, widths
`ifndef PULSE_GEN_CFG_SVH
`define PULSE_GEN_CFG_SVH

// mode_select encodings of the even channel
`define MODE_CASCADE      2'h1
`define MODE_WIDE         2'h2

// clock_select encodings: peripheral clock divided by 1, 4, 16, 64
`define CLKSEL_DIV1       2'h0
`define CLKSEL_DIV4       2'h1
`define CLKSEL_DIV16      2'h2
`define CLKSEL_DIV64      2'h3

// shared prescale counter, cleared while no channel runs, and the masks that pick each rate
`define PRESCALE_BITS     6
`define PRESCALE_MASK4    6'h03
`define PRESCALE_MASK16   6'h0f
`define PRESCALE_MASK64   6'h3f

// reload field widths and reset values
`define RELOAD_BITS       8
`define COUNT_BITS        16
`define COUNT_RESET       16'h0000
`define RELOAD_PAD        8'h00

`endif

/* verilog/pulse_gen_pkg.sv */
// types shared by the paired pulse generator modules
package pulse_gen_pkg;

    // how the two channels are tied together
    typedef enum logic [1:0] {
        mode_single,
        mode_cascade,
        mode_wide
    } op_mode_t;

    // phase of one pulse channel counter
    typedef enum logic [1:0] {
        phase_idle,
        phase_low,
        phase_high
    } phase_t;

    typedef logic [1:0] clk_sel_t;

endpackage

/* verilog/pulse_gen_tick_if.sv */
// carrier between the top and the count clock divider
`timescale 1ns/1ns
`default_nettype none

interface pulse_gen_tick_if;
    logic [1:0] run;   // channel running, divider counts only while any runs
    logic [1:0] sel0;  // clock_select of channel 0
    logic [1:0] sel1;  // clock_select of channel 1
    logic [1:0] tick;  // one-cycle count clock enables, one per channel

    modport divider (input run, input sel0, input sel1, output tick);
    modport user    (output run, output sel0, output sel1, input tick);
endinterface

`default_nettype wire

/* verilog/count_clock_divider.sv */
// count clock divider: one-cycle enable pulses at the selected prescale
`timescale 1ns/1ns
`default_nettype none

`include "pulse_gen_cfg.svh"

module count_clock_divider (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // selects in, ticks out
    pulse_gen_tick_if.divider tk
);
    import pulse_gen_pkg::*;

    logic [`PRESCALE_BITS-1:0] pre_q;

    // ---------------------------------------------------------------
    // shared prescale counter
    // ---------------------------------------------------------------
    // restarts while idle so the first period after a start is whole
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q <= '0;
        end else if (tk.run == 2'b00) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // per channel rate pick
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_tick
            clk_sel_t sel;
            assign sel = (gi == 0) ? tk.sel0 : tk.sel1;
            always_comb begin
                case (sel)
                    `CLKSEL_DIV1:  tk.tick[gi] = tk.run[gi];
                    `CLKSEL_DIV4:  tk.tick[gi] = tk.run[gi]
                                               && ((pre_q & `PRESCALE_MASK4) == '0);
                    `CLKSEL_DIV16: tk.tick[gi] = tk.run[gi]
                                               && ((pre_q & `PRESCALE_MASK16) == '0);
                    default:       tk.tick[gi] = tk.run[gi]
                                               && ((pre_q & `PRESCALE_MASK64) == '0);
                endcase
            end
        end
    endgenerate

endmodule // count_clock_divider

`default_nettype wire

/* verilog/pulse_gen_channel.sv */
// one pulse channel: down counter alternating low and high widths
`timescale 1ns/1ns
`default_nettype none

`include "pulse_gen_cfg.svh"

module pulse_gen_channel (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // control
    input  wire logic                    run,
    input  wire logic                    tick,
    // widths, reload value plus one ticks each
    input  wire logic [`COUNT_BITS-1:0]  low_width,
    input  wire logic [`COUNT_BITS-1:0]  high_width,
    // results
    output logic                         level,
    output logic                         low_end,
    output logic                         high_end
);
    import pulse_gen_pkg::*;

    phase_t                  phase_q;
    logic [`COUNT_BITS-1:0]  count_q;
    logic [`COUNT_BITS-1:0]  high_buf_q;
    logic                    expire;

    assign expire   = run && tick && (count_q == `COUNT_RESET);
    assign low_end  = expire && (phase_q == phase_low);
    assign high_end = expire && (phase_q == phase_high);
    assign level    = (phase_q == phase_high);

    // ---------------------------------------------------------------
    // counter and phase
    // ---------------------------------------------------------------
    // widths load at the start moment, not at the enable; the high width
    // is buffered with the low one so a pair always stays matched
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q    <= phase_idle;
            count_q    <= `COUNT_RESET;
            high_buf_q <= `COUNT_RESET;
        end else if (!run) begin
            phase_q    <= phase_idle;
            count_q    <= `COUNT_RESET;
        end else begin
            case (phase_q)
                phase_idle: begin
                    phase_q    <= phase_low;
                    count_q    <= low_width;
                    high_buf_q <= high_width;
                end
                phase_low: begin
                    if (tick) begin
                        if (count_q == `COUNT_RESET) begin
                            phase_q <= phase_high;
                            count_q <= high_buf_q;
                        end else begin
                            count_q <= count_q - 1'b1;
                        end
                    end
                end
                phase_high: begin
                    if (tick) begin
                        if (count_q == `COUNT_RESET) begin
                            phase_q    <= phase_low;
                            count_q    <= low_width;
                            high_buf_q <= high_width;
                        end else begin
                            count_q <= count_q - 1'b1;
                        end
                    end
                end
                default: begin
                    phase_q <= phase_idle;
                end
            endcase
        end
    end

endmodule // pulse_gen_channel

`default_nettype wire

/* verilog/paired_channel_pulse_generator.sv */
// paired pulse generator: cascaded 8+8 and combined 16-bit modes
`timescale 1ns/1ns
`default_nettype none

`include "pulse_gen_cfg.svh"

module paired_channel_pulse_generator (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    // run enables, written together by software
    input  wire logic                         channel0_run_enable,
    input  wire logic                         channel1_run_enable,
    // control for both channels; mode_select is the even channel's field
    input  wire logic [1:0]                   mode_select,
    input  wire pulse_gen_pkg::clk_sel_t      clock_select_ch0,
    input  wire pulse_gen_pkg::clk_sel_t      clock_select_ch1,
    input  wire logic [1:0]                   interrupt_timing,
    input  wire logic [1:0]                   interrupt_enable,
    input  wire logic                         polarity_invert_ch0,
    input  wire logic                         polarity_invert_ch1,
    // reload values per channel
    input  wire logic [`RELOAD_BITS-1:0]      low_width_reload_ch0,
    input  wire logic [`RELOAD_BITS-1:0]      high_width_reload_ch0,
    input  wire logic [`RELOAD_BITS-1:0]      low_width_reload_ch1,
    input  wire logic [`RELOAD_BITS-1:0]      high_width_reload_ch1,
    // software write of zero to an underflow flag, one-cycle pulse
    input  wire logic [1:0]                   underflow_flag_clear,
    // status and interrupt
    output logic [1:0]                        underflow_flag,
    output logic [1:0]                        interrupt_request,
    // pulse pins
    output logic [1:0]                        pulse_out
);
    import pulse_gen_pkg::*;

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    op_mode_t mode;

    // only the even channel's field decides the pairing
    always_comb begin
        case (mode_select)
            `MODE_CASCADE: mode = mode_cascade;
            `MODE_WIDE:    mode = mode_wide;
            default:       mode = mode_single;
        endcase
    end

    // ---------------------------------------------------------------
    // count clock enables
    // ---------------------------------------------------------------
    pulse_gen_tick_if tk ();

    logic                        run0;
    logic                        run1;
    logic                        tick0;
    logic                        out_go_q;
    logic                        pre_low_end;
    logic                        pre_high_end;
    logic                        out_low_end;
    logic                        out_high_end;
    logic                        pre_level;
    logic                        out_level;

    // in the joined mode the odd counter is unused: one 16-bit counter
    // in channel 0 does the work, fed by channel 0's clock_select
    assign tk.run[0] = run0 && (mode != mode_cascade);
    assign tk.run[1] = run1;
    assign tk.sel0   = clock_select_ch0;
    assign tk.sel1   = clock_select_ch1;

    count_clock_divider u_div (
        .clk     (clk),
        .reset_n (reset_n),
        .tk      (tk.divider)
    );

    // cascade: the even clock_select is not looked at, the output side
    // steps on every edge of the prescaler output instead
    always_comb begin
        if (mode == mode_cascade) begin
            tick0 = pre_low_end || pre_high_end;
        end else begin
            tick0 = tk.tick[0];
        end
    end

    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    // in single mode each channel follows its own enable, so enables set or cleared in
    // separate writes shift the two channels against each other
    assign run1 = channel1_run_enable && (mode != mode_wide);
    assign run0 = channel0_run_enable
               && ((mode != mode_cascade) || out_go_q);

    // output side is held until the first prescaler low width is over
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_go_q <= 1'b0;
        end else if (!channel0_run_enable || !channel1_run_enable
                     || (mode != mode_cascade)) begin
            out_go_q <= 1'b0;
        end else if (pre_low_end) begin
            out_go_q <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // width selection
    // ---------------------------------------------------------------
    logic [`COUNT_BITS-1:0] low_w0;
    logic [`COUNT_BITS-1:0] high_w0;
    logic [`COUNT_BITS-1:0] low_w1;
    logic [`COUNT_BITS-1:0] high_w1;

    // joined mode: odd pair forms the low width, even pair the high width
    always_comb begin
        if (mode == mode_wide) begin
            low_w0  = {high_width_reload_ch1, low_width_reload_ch1};
            high_w0 = {high_width_reload_ch0, low_width_reload_ch0};
        end else begin
            low_w0  = {`RELOAD_PAD, low_width_reload_ch0};
            high_w0 = {`RELOAD_PAD, high_width_reload_ch0};
        end
    end

    assign low_w1  = {`RELOAD_PAD, low_width_reload_ch1};
    assign high_w1 = {`RELOAD_PAD, high_width_reload_ch1};

    // ---------------------------------------------------------------
    // the two counters
    // ---------------------------------------------------------------
    // channel 0 is the output side in cascade and the whole counter
    // when joined; with unequal prescaler widths an odd output count
    // lands on an uneven mix of low and high periods
    pulse_gen_channel u_out (
        .clk        (clk),
        .reset_n    (reset_n),
        .run        (run0),
        .tick       (tick0),
        .low_width  (low_w0),
        .high_width (high_w0),
        .level      (out_level),
        .low_end    (out_low_end),
        .high_end   (out_high_end)
    );

    // channel 1 is the prescaler side in cascade, its own clock always
    pulse_gen_channel u_pre (
        .clk        (clk),
        .reset_n    (reset_n),
        .run        (run1),
        .tick       (tk.tick[1]),
        .low_width  (low_w1),
        .high_width (high_w1),
        .level      (pre_level),
        .low_end    (pre_low_end),
        .high_end   (pre_high_end)
    );

    // ---------------------------------------------------------------
    // underflow flags and interrupt requests
    // ---------------------------------------------------------------
    logic [1:0] low_ev;
    logic [1:0] high_ev;
    logic [1:0] flag_q;
    logic [1:0] irq_q;

    // joined mode drives both flags from the single combined counter
    always_comb begin
        low_ev[0]  = out_low_end;
        high_ev[0] = out_high_end;
        if (mode == mode_wide) begin
            low_ev[1]  = out_low_end;
            high_ev[1] = out_high_end;
        end else begin
            low_ev[1]  = pre_low_end;
            high_ev[1] = pre_high_end;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
            logic set_ev;

            // timing 0 counts both pulse ends, timing 1 only the high end
            assign set_ev = high_ev[gi]
                         || (!interrupt_timing[gi] && low_ev[gi]);

            // a set in the clearing cycle wins so no underflow is lost
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    flag_q[gi] <= 1'b0;
                end else if (set_ev) begin
                    flag_q[gi] <= 1'b1;
                end else if (underflow_flag_clear[gi]) begin
                    flag_q[gi] <= 1'b0;
                end
            end

            // request follows flag and enable, one cycle behind the flag
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    irq_q[gi] <= 1'b0;
                end else begin
                    irq_q[gi] <= flag_q[gi] && interrupt_enable[gi];
                end
            end
        end
    endgenerate

    assign underflow_flag    = flag_q;
    assign interrupt_request = irq_q;

    // ---------------------------------------------------------------
    // output pins
    // ---------------------------------------------------------------
    logic [1:0] pin_q;

    // registered so the pins never glitch on decode changes; stopped
    // channels rest low, or high when inverted
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_q <= 2'b00;
        end else begin
            pin_q[0] <= out_level ^ polarity_invert_ch0;
            if (mode == mode_wide) begin
                pin_q[1] <= out_level ^ polarity_invert_ch1;
            end else begin
                pin_q[1] <= pre_level ^ polarity_invert_ch1;
            end
        end
    end

    assign pulse_out = pin_q;

endmodule // paired_channel_pulse_generator

`default_nettype wire

/* verif/paired_channel_pulse_generator_properties.sv */
// port-level assertions for the paired pulse generator, bound to its top
`timescale 1ns/1ns
`default_nettype none

`include "pulse_gen_cfg.svh"

module pulse_gen_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // control inputs
    input wire logic       channel0_run_enable,
    input wire logic       channel1_run_enable,
    input wire logic [1:0] mode_select,
    input wire logic [1:0] interrupt_timing,
    input wire logic [1:0] interrupt_enable,
    input wire logic       polarity_invert_ch0,
    input wire logic       polarity_invert_ch1,
    input wire logic [1:0] underflow_flag_clear,
    // outputs
    input wire logic [1:0] underflow_flag,
    input wire logic [1:0] interrupt_request,
    input wire logic [1:0] pulse_out
);
    // both enables low means nothing may count
    wire logic       idle = !channel0_run_enable && !channel1_run_enable;
    wire logic [1:0] inv  = {polarity_invert_ch1, polarity_invert_ch0};

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // flags and requests
    // ------------------------------------------------------------
    chk_irq_gate: assert property (
        interrupt_request == $past(underflow_flag & interrupt_enable))
        else $error("request differs from flag and enable");
    chk_flag_sticky: assert property (
        underflow_flag[0] && !underflow_flag_clear[0] |=> underflow_flag[0])
        else $error("flag dropped without a clear");
    chk_wide_pair: assert property (
        mode_select == `MODE_WIDE && $rose(underflow_flag[0]) |-> underflow_flag[1])
        else $error("combined mode flags not set together");
    chk_high_end: assert property (
        interrupt_timing[0] && !polarity_invert_ch0 && $rose(underflow_flag[0])
        |-> pulse_out[0] ##1 !pulse_out[0])
        else $error("flag set outside the high pulse end");
    chk_flag_edge: assert property (
        $rose(underflow_flag[0]) && channel0_run_enable |=> $changed(pulse_out[0]))
        else $error("flag without an output toggle");

    // ------------------------------------------------------------
    // pins and stopping
    // ------------------------------------------------------------
    chk_wide_copy: assert property (
        mode_select == `MODE_WIDE && $stable(mode_select) && inv == 2'b00
        |-> pulse_out[1] == pulse_out[0])
        else $error("odd pin differs in combined mode");
    chk_stop_level: assert property (
        (idle && $stable(inv)) [*3] |-> pulse_out == inv)
        else $error("stopped pins not at inversion level");
    chk_idle_quiet: assert property (
        idle [*3] |-> !$rose(underflow_flag[0]) && !$rose(underflow_flag[1]))
        else $error("flag set while stopped");

    // main scenarios reached
    cov_cascade: cover property (mode_select == `MODE_CASCADE && $rose(underflow_flag[0]));
    cov_wide: cover property (mode_select == `MODE_WIDE && $rose(underflow_flag[1]));
    cov_irq: cover property ($rose(interrupt_request[0]));
endmodule // pulse_gen_checker

bind paired_channel_pulse_generator pulse_gen_checker chk_u (
    .clk(clk), .reset_n(reset_n),
    .channel0_run_enable(channel0_run_enable), .channel1_run_enable(channel1_run_enable),
    .mode_select(mode_select), .interrupt_timing(interrupt_timing),
    .interrupt_enable(interrupt_enable), .polarity_invert_ch0(polarity_invert_ch0),
    .polarity_invert_ch1(polarity_invert_ch1), .underflow_flag_clear(underflow_flag_clear),
    .underflow_flag(underflow_flag), .interrupt_request(interrupt_request),
    .pulse_out(pulse_out)
);

`default_nettype wire

/* verif/pulse_width_monitor.sv */
// receiving circuit model: times every level segment on both pins
`timescale 1ns/1ns
`default_nettype none

module pulse_width_monitor (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // pins from the generator
    input  wire logic [1:0]  pulse,
    // one report per pin edge: level that ended and its length in cycles
    output logic [1:0]       meas_valid,
    output logic [1:0]       meas_level,
    output logic [1:0][15:0] meas_len
);
    logic [1:0]       prev_q;
    logic [1:0][15:0] cnt_q;

    // ------------------------------------------------------------
    // segment timer
    // ------------------------------------------------------------
    // no saturation: segments in this bench stay far below 16 bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q     <= 2'b00;
            cnt_q      <= '0;
            meas_valid <= 2'b00;
            meas_level <= 2'b00;
            meas_len   <= '0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                meas_valid[n] <= (pulse[n] != prev_q[n]);
                if (pulse[n] != prev_q[n]) begin
                    meas_len[n]   <= cnt_q[n];
                    meas_level[n] <= prev_q[n];
                    cnt_q[n]      <= 16'h0001;
                end else begin
                    cnt_q[n] <= cnt_q[n] + 16'h0001;
                end
            end
            prev_q <= pulse;
        end
    end
endmodule // pulse_width_monitor

`default_nettype wire

/* verif/paired_channel_pulse_generator_tb.sv */
// self-checking bench for the paired pulse generator
`timescale 1ns/1ns
`default_nettype none

`include "pulse_gen_cfg.svh"

module paired_channel_pulse_generator_tb;
    import pulse_gen_pkg::*;

    // design inputs
    logic                    clk = 1'b0;
    logic                    reset_n = 1'b0;
    logic                    channel0_run_enable = 1'b0;
    logic                    channel1_run_enable = 1'b0;
    logic                    polarity_invert_ch0 = 1'b0;
    logic                    polarity_invert_ch1 = 1'b0;
    logic [1:0]              mode_select = 2'h0;
    logic [1:0]              interrupt_timing = 2'h0;
    logic [1:0]              interrupt_enable = 2'h0;
    logic [1:0]              underflow_flag_clear = 2'h0;
    clk_sel_t                clock_select_ch0 = 2'h0;
    clk_sel_t                clock_select_ch1 = 2'h0;
    logic [`RELOAD_BITS-1:0] low0 = 8'h00, high0 = 8'h00, low1 = 8'h00, high1 = 8'h00;
    // outputs and measurements
    logic [1:0]              underflow_flag, interrupt_request, pulse_out;
    logic [1:0]              meas_valid, meas_level;
    logic [1:0][15:0]        meas_len;
    // expected segments per pin, -1 means not timed
    int                      fail_count = 0;
    int                      num_checks = 0;
    int                      exp_q [2][$];
    logic [31:0]             rnd_q = 32'h3740_c6e0;

    always #2 clk = ~clk;

    paired_channel_pulse_generator dut_u (
        .clk(clk), .reset_n(reset_n),
        .channel0_run_enable(channel0_run_enable), .channel1_run_enable(channel1_run_enable),
        .mode_select(mode_select), .clock_select_ch0(clock_select_ch0),
        .clock_select_ch1(clock_select_ch1), .interrupt_timing(interrupt_timing),
        .interrupt_enable(interrupt_enable), .polarity_invert_ch0(polarity_invert_ch0),
        .polarity_invert_ch1(polarity_invert_ch1), .low_width_reload_ch0(low0),
        .high_width_reload_ch0(high0), .low_width_reload_ch1(low1),
        .high_width_reload_ch1(high1), .underflow_flag_clear(underflow_flag_clear),
        .underflow_flag(underflow_flag), .interrupt_request(interrupt_request),
        .pulse_out(pulse_out)
    );

    pulse_width_monitor mon_u (
        .clk(clk), .reset_n(reset_n), .pulse(pulse_out),
        .meas_valid(meas_valid), .meas_level(meas_level), .meas_len(meas_len)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic compare_width(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: segment %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic compare_bits(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: bits %b expected %b", $time, got, exp);
        end
    endtask

    // the first segment spans idle time, so it is only counted off
    task automatic expect_run(input int ch, input int ph, input int pl, input logic inv);
        exp_q[ch].push_back(-1);
        exp_q[ch].push_back({15'h0, ~inv, 16'(ph)});
        exp_q[ch].push_back({15'h0, inv, 16'(pl)});
        exp_q[ch].push_back({15'h0, ~inv, 16'(ph)});
    endtask

    task automatic clear_flags;
        @(posedge clk);
        underflow_flag_clear <= 2'b11;
        @(posedge clk);
        underflow_flag_clear <= 2'b00;
        repeat (2) @(posedge clk); // let pin edges drain
    endtask

    task automatic wait_empty;
        int i;
        for (i = 0; i < 20000 && exp_q[0].size() + exp_q[1].size() > 0; i++) @(posedge clk);
        if (i == 20000) begin
            fail_count++;
            $display("mismatch at %0t: segments missing", $time);
            end_sim();
        end
    endtask

    // stop both channels in one write, then check flags, requests and pins
    task automatic stop_run(input logic [1:0] flags, input logic [1:0] irq);
        wait_empty();
        @(posedge clk);
        {channel1_run_enable, channel0_run_enable} <= 2'b00;
        repeat (8) @(posedge clk);
        @(negedge clk);
        compare_bits(underflow_flag, flags);
        compare_bits(interrupt_request, irq);
        compare_bits(pulse_out, {polarity_invert_ch1, polarity_invert_ch0});
        clear_flags();
        @(negedge clk);
        compare_bits(underflow_flag | interrupt_request, 2'b00);
        $display("test done at %0t", $time);
    endtask

    // oldest note against each measured segment
    always @(posedge clk) begin
        int e;
        for (int n = 0; n < 2; n++) begin
            if (meas_valid[n] === 1'b1 && exp_q[n].size() > 0) begin
                e = exp_q[n].pop_front();
                if (e != -1) begin
                    compare_width({15'h0, meas_level[n], meas_len[n]}, e);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int r, qv, qw, a, b;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        // cascade runs; the second inverts both pins
        for (r = 0; r < 2; r++) begin
            rnd_q = lfsr(rnd_q);
            qv = 1 + rnd_q[0];
            qw = (qv + 1) * 4;
            a = rnd_q[3:1];
            b = rnd_q[6:4];
            @(posedge clk);
            mode_select <= `MODE_CASCADE;
            clock_select_ch1 <= `CLKSEL_DIV4;
            clock_select_ch0 <= `CLKSEL_DIV64;
            low1 <= 8'(qv);
            high1 <= 8'(qv);
            low0 <= 8'hff;
            high0 <= 8'hff;
            {polarity_invert_ch1, polarity_invert_ch0} <= {2{r[0]}};
            interrupt_timing <= 2'b00;
            interrupt_enable <= 2'b11;
            clear_flags();
            expect_run(0, (b + 1) * qw, (a + 1) * qw, r[0]);
            expect_run(1, qw, qw, r[0]);
            @(posedge clk);
            {channel1_run_enable, channel0_run_enable} <= 2'b11;
            @(posedge clk);
            low0 <= 8'(a);
            high0 <= 8'(b);
            stop_run(2'b11, 2'b11);
        end
        // combined 16-bit run, low width above one byte
        rnd_q = lfsr(rnd_q);
        @(posedge clk);
        mode_select <= `MODE_WIDE;
        clock_select_ch0 <= `CLKSEL_DIV4;
        clock_select_ch1 <= `CLKSEL_DIV4;
        low1 <= rnd_q[7:0];
        high1 <= 8'h01;
        low0 <= rnd_q[15:8];
        high0 <= 8'h00;
        {polarity_invert_ch1, polarity_invert_ch0} <= 2'b00;
        interrupt_timing <= 2'b11;
        interrupt_enable <= 2'b01;
        clear_flags();
        for (r = 0; r < 2; r++) begin
            expect_run(r, (rnd_q[15:8] + 1) * 4, (rnd_q[7:0] + 257) * 4, 1'b0);
        end
        @(posedge clk);
        {channel1_run_enable, channel0_run_enable} <= 2'b11;
        stop_run(2'b11, 2'b01);
        end_sim();
    end
endmodule // paired_channel_pulse_generator_tb

`default_nettype wire
